// [cse_pkg.sv]
// constants, opcodes and flag layout for the compare and skip execution block
// assumes an 8-bit data path and a 16-bit word-addressed program counter
package cse_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int BIT_SEL_W = 3;
	localparam int IO_ADDR_W = 5;
	// flag positions in the status byte
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam int HALF_MSB = 3;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// program counter step for a fall-through instruction
	localparam logic [15:0] PC_STEP = 16'h0001;
	// cycles of a skip: not taken, over one word, over two words
	localparam logic [1:0] CYC_NO_SKIP = 2'h1;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
	localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
	typedef enum logic [2:0] {
		CSE_OP_NONE,
		CSE_OP_CMP,
		CSE_OP_CMP_CARRY,
		CSE_OP_CMP_IMM,
		CSE_OP_SKIP_REG_LOW,
		CSE_OP_SKIP_REG_HIGH,
		CSE_OP_SKIP_IO_LOW,
		CSE_OP_SKIP_IO_HIGH
	} cse_op_type;
endpackage : cse_pkg

// [cse_sub_flags.sv]
// subtractor with flag outputs for the compare operations
// assumes purely combinational use inside one core cycle
`timescale 1ns/1ps
module cse_sub_flags #(
	parameter int WIDTH = cse_pkg::DATA_W
) (
	// operands
	input wire logic [WIDTH-1:0] i_minuend,
	input wire logic [WIDTH-1:0] i_subtrahend,
	input wire logic i_borrow_in,
	input wire logic i_chain_zero,
	// flags
	output logic o_zero,
	output logic o_negative,
	output logic o_overflow,
	output logic o_carry,
	output logic o_half
);
	logic [WIDTH:0] diff;
	logic [WIDTH-1:0] res;
	logic [WIDTH-1:0] bw;
	always_comb begin
		diff = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {{WIDTH{1'b0}}, i_borrow_in};
		res = diff[WIDTH-1:0];
		// borrow vector: b = ~a&s | s&r | r&~a
		bw = (~i_minuend & i_subtrahend) | (i_subtrahend & res) | (res & ~i_minuend);
		// with a borrow in, zero can be kept or cleared but never newly set; with no borrow in it follows the result
		o_zero = (res == '0) && (i_chain_zero || !i_borrow_in);
		o_negative = res[WIDTH-1];
		o_overflow = (i_minuend[WIDTH-1] & ~i_subtrahend[WIDTH-1] & ~res[WIDTH-1])
			| (~i_minuend[WIDTH-1] & i_subtrahend[WIDTH-1] & res[WIDTH-1]);
		o_carry = bw[WIDTH-1];
		o_half = bw[cse_pkg::HALF_MSB];
	end
endmodule : cse_sub_flags

// [cse_exec.sv]
// compare and conditional-skip execution stage of an 8-bit core
// assumes the decoder presents one instruction per i_issue pulse with operands valid,
// and says whether the following instruction is two words long
// How it works
// - a register compare subtracts the second operand from the destination and sets Z N V C H in one cycle.
// - a compare with carry also subtracts the current carry and sets Z N V C H in one cycle.
// - a compare with immediate subtracts the encoded constant and sets Z N V C H in one cycle.
// - skip_on_reg_bit_low skips the next instruction when the chosen register bit is zero, flags untouched.
// - skip_on_reg_bit_high skips the next instruction when the chosen register bit is one, flags untouched.
// - skip_on_io_bit_low skips the next instruction when the chosen I/O bit is zero, flags untouched.
// - skip_on_io_bit_high skips the next instruction when the chosen I/O bit is one, flags untouched.
`timescale 1ns/1ps
module cse_exec #(
	parameter int DATA_W = cse_pkg::DATA_W,
	parameter int PC_W = cse_pkg::PC_W
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// instruction from the decoder
	input wire logic i_issue,
	input wire cse_pkg::cse_op_type i_op,
	input wire logic [DATA_W-1:0] i_dest_operand,
	input wire logic [DATA_W-1:0] i_second_operand,
	input wire logic [DATA_W-1:0] i_immediate,
	input wire logic [cse_pkg::BIT_SEL_W-1:0] i_bit_sel,
	input wire logic [cse_pkg::IO_ADDR_W-1:0] i_io_addr,
	input wire logic i_next_is_two_word,
	// i/o space read port
	input wire logic [DATA_W-1:0] i_io_rdata,
	output logic [cse_pkg::IO_ADDR_W-1:0] o_io_addr,
	// status flags
	output logic [7:0] o_status,
	// program counter
	output logic [PC_W-1:0] o_program_counter,
	output logic o_busy,
	output logic o_done,
	output logic o_skip_taken
);
	// stall states of a taken skip; the fourth code is never reached
	typedef enum logic [1:0] {
		ST_READY,
		ST_STALL_FIRST,
		ST_STALL_LAST
	} cse_state_type;

	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	cse_state_type state_reg;
	cse_state_type state_next;
	logic done_reg;
	logic skip_reg;
	logic f_z;
	logic f_n;
	logic f_v;
	logic f_c;
	logic f_h;
	logic [DATA_W-1:0] sub_b;
	logic borrow_in;
	logic is_cmp;
	logic is_skip;
	logic test_bit;
	logic skip_cond;
	logic start;
	logic take;
	logic [PC_W-1:0] advance;

	// the i/o address goes straight out so the read data is back in the issue cycle
	assign o_io_addr = i_io_addr;
	assign o_status = status_reg;
	assign o_program_counter = pc_reg;
	assign o_done = done_reg;
	assign o_skip_taken = skip_reg;
	assign o_busy = (state_reg != ST_READY);
	// issues while busy are ignored: the core stalls over a skipped slot
	assign start = i_issue && !o_busy;

	always_comb begin
		is_cmp = 1'b0;
		is_skip = 1'b0;
		sub_b = i_second_operand;
		borrow_in = 1'b0;
		test_bit = 1'b0;
		skip_cond = 1'b0;
		unique case (i_op)
			cse_pkg::CSE_OP_NONE: begin
			end
			cse_pkg::CSE_OP_CMP: begin
				is_cmp = 1'b1;
			end
			cse_pkg::CSE_OP_CMP_CARRY: begin
				is_cmp = 1'b1;
				borrow_in = status_reg[cse_pkg::FLAG_C];
			end
			cse_pkg::CSE_OP_CMP_IMM: begin
				is_cmp = 1'b1;
				sub_b = i_immediate;
			end
			cse_pkg::CSE_OP_SKIP_REG_LOW: begin
				is_skip = 1'b1;
				test_bit = i_second_operand[i_bit_sel];
				skip_cond = !test_bit;
			end
			cse_pkg::CSE_OP_SKIP_REG_HIGH: begin
				is_skip = 1'b1;
				test_bit = i_second_operand[i_bit_sel];
				skip_cond = test_bit;
			end
			cse_pkg::CSE_OP_SKIP_IO_LOW: begin
				is_skip = 1'b1;
				test_bit = i_io_rdata[i_bit_sel];
				skip_cond = !test_bit;
			end
			cse_pkg::CSE_OP_SKIP_IO_HIGH: begin
				is_skip = 1'b1;
				test_bit = i_io_rdata[i_bit_sel];
				skip_cond = test_bit;
			end
		endcase
	end

	cse_sub_flags #(
		.WIDTH(DATA_W)
	) u_sub (
		.i_minuend(i_dest_operand),
		.i_subtrahend(sub_b),
		.i_borrow_in(borrow_in),
		.i_chain_zero(status_reg[cse_pkg::FLAG_Z]),
		.o_zero(f_z),
		.o_negative(f_n),
		.o_overflow(f_v),
		.o_carry(f_c),
		.o_half(f_h)
	);

	// the difference is only used for flags; no register write port exists here
	always_comb begin
		status_next = status_reg;
		if (start && is_cmp) begin
			status_next[cse_pkg::FLAG_Z] = f_z;
			status_next[cse_pkg::FLAG_N] = f_n;
			status_next[cse_pkg::FLAG_V] = f_v;
			status_next[cse_pkg::FLAG_C] = f_c;
			status_next[cse_pkg::FLAG_H] = f_h;
		end
	end

	// pc moves at issue; a taken skip then stalls so the skipped slot is never fetched
	always_comb begin
		advance = PC_W'(cse_pkg::PC_STEP);
		if (is_skip && skip_cond) begin
			advance = i_next_is_two_word ? PC_W'(cse_pkg::PC_SKIP_TWO) : PC_W'(cse_pkg::PC_SKIP_ONE);
		end
		pc_next = pc_reg;
		if (start) begin
			pc_next = pc_reg + advance;
		end
	end

	assign take = start && is_skip && skip_cond;

	// the issue cycle is the first of the cost, so a taken skip adds one or two stall cycles
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_READY: begin
				if (take) begin
					state_next = i_next_is_two_word ? ST_STALL_FIRST : ST_STALL_LAST;
				end
			end
			ST_STALL_FIRST: begin
				state_next = ST_STALL_LAST;
			end
			ST_STALL_LAST: begin
				state_next = ST_READY;
			end
			default: begin
				state_next = ST_READY;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_reg <= cse_pkg::STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_reg <= PC_W'(cse_pkg::PC_RESET);
		end else begin
			pc_reg <= pc_next;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_READY;
		end else begin
			state_reg <= state_next;
		end
	end

	// done is high in the cycle after the last cycle of each instruction
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= (start && !take) || (state_reg == ST_STALL_LAST);
		end
	end

	// skip_taken holds the last verdict until the next accepted instruction; compares clear it
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			skip_reg <= 1'b0;
		end else begin
			if (start) begin
				skip_reg <= take;
			end
		end
	end
endmodule : cse_exec

// [cse_exec_assertions.sv]
// port assertions for the compare and skip stage
// assumes a bind onto cse_exec, one clock domain
`timescale 1ns/1ps
module cse_exec_chk (
	// watched ports
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_issue,
	input wire cse_pkg::cse_op_type i_op,
	input wire logic [7:0] i_dest_operand,
	input wire logic [7:0] i_second_operand,
	input wire logic [7:0] i_immediate,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_next_is_two_word,
	input wire logic [7:0] i_io_rdata,
	input wire logic [7:0] o_status,
	input wire logic [15:0] o_program_counter,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_skip_taken
);
	wire logic tk = i_issue & ~o_busy;
	wire logic cmp = tk & (i_op != cse_pkg::CSE_OP_NONE) & ~i_op[2];
	wire logic skp = tk & i_op[2];
	// i/o skips test the read data, register skips the second operand
	wire logic hit = skp & ((i_op[1] ? i_io_rdata[i_bit_sel] : i_second_operand[i_bit_sel]) == i_op[0]);
	wire logic [8:0] bw = {1'h0, i_dest_operand} - (i_op == cse_pkg::CSE_OP_CMP_IMM ? i_immediate : i_second_operand)
		- (i_op == cse_pkg::CSE_OP_CMP_CARRY ? o_status[0] : 1'h0);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_one;
		hit && !i_next_is_two_word;
	endsequence
	sequence s_two;
		hit && i_next_is_two_word;
	endsequence
	a_cmp_end: assert property (cmp |=> o_done &&
		o_program_counter == $past(o_program_counter) + 16'h1) else $error("compare end");
	a_cmp_zero: assert property (cmp && i_op == cse_pkg::CSE_OP_CMP |=>
		o_status[1] == ($past(i_dest_operand) == $past(i_second_operand))) else $error("compare zero");
	a_cmp_carry_borrow: assert property (cmp && i_op == cse_pkg::CSE_OP_CMP_CARRY |=>
		o_status[0] == $past(bw[8])) else $error("carry compare borrow");
	a_cmp_imm_borrow: assert property (cmp && i_op == cse_pkg::CSE_OP_CMP_IMM |=>
		o_status[0] == $past(bw[8])) else $error("immediate compare borrow");
	a_skip_flags: assert property (skp |=> $stable(o_status)) else $error("skip flags");
	a_skip_pc: assert property (hit |=> o_skip_taken &&
		o_program_counter == $past(o_program_counter) + ($past(i_next_is_two_word) ? 16'h3 : 16'h2)) else $error("skip pc");
	a_skip_one: assert property (s_one |=> o_busy ##1 (!o_busy && o_done)) else $error("skip one");
	a_skip_two: assert property (s_two |=> o_busy [*2] ##1 (!o_busy && o_done)) else $error("skip two");
	a_skip_miss: assert property (skp && !hit |=> o_done && !o_busy && !o_skip_taken &&
		o_program_counter == $past(o_program_counter) + 16'h1) else $error("skip not taken");
	a_busy_hold: assert property (o_busy |=> $stable(o_status) && $stable(o_program_counter)) else $error("stall moved state");
endmodule : cse_exec_chk

// [cse_exec_tb.sv]
// random bench for cse_exec against a behavioural model
// assumes cse_exec_chk is compiled before it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module cse_exec_tb;
	logic i_mclk = 1'h0;
	logic i_rst_n = 1'h0;
	logic i_issue = 1'h0;
	logic i_next_is_two_word = 1'h0;
	cse_pkg::cse_op_type i_op = cse_pkg::CSE_OP_NONE;
	logic [7:0] i_dest_operand = '0, i_second_operand = '0, i_immediate = '0, i_io_rdata = '0, o_status, st = '0;
	logic [2:0] i_bit_sel = '0;
	logic [4:0] i_io_addr = '0, o_io_addr;
	logic [15:0] o_program_counter, pc = '0;
	logic o_busy, o_done, o_skip_taken;
	int n_fail = 0, tests_run = 0;
	int exp_q[$];
	always #25 i_mclk = ~i_mclk;
	cse_exec DUT (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_issue(i_issue),
		.i_op(i_op),
		.i_dest_operand(i_dest_operand),
		.i_second_operand(i_second_operand),
		.i_immediate(i_immediate),
		.i_bit_sel(i_bit_sel),
		.i_io_addr(i_io_addr),
		.i_next_is_two_word(i_next_is_two_word),
		.i_io_rdata(i_io_rdata),
		.o_io_addr(o_io_addr),
		.o_status(o_status),
		.o_program_counter(o_program_counter),
		.o_busy(o_busy),
		.o_done(o_done),
		.o_skip_taken(o_skip_taken)
	);
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic run(input cse_pkg::cse_op_type op, input logic [7:0] d, s, k, input logic [2:0] b, input logic two);
		logic [7:0] sub;
		logic [8:0] r;
		logic [4:0] hr;
		logic cin, hit;
		int n, exp_cyc;
		sub = op == cse_pkg::CSE_OP_CMP_IMM ? k : s;
		cin = op == cse_pkg::CSE_OP_CMP_CARRY && st[0];
		r = {1'h0, d} - sub - cin;
		hr = {1'h0, d[3:0]} - sub[3:0] - cin;
		hit = op[2] && (op[1] ? ~s[b] : s[b]) == op[0];
		// with a borrow in, the carry compare keeps zero only if it was already set
		if (op != cse_pkg::CSE_OP_NONE && !op[2])
			st = {2'h0, hr[4], 1'h0, (d[7] ^ sub[7]) & (d[7] ^ r[7]), r[7], r[7:0] == 8'h0 && (!cin || st[1]), r[8]};
		pc = pc + (hit ? 16'h2 + two : 16'h1);
		exp_q.push_back(hit ? 2 + two : 1);
		@(posedge i_mclk);
		i_issue <= 1'h1;
		i_op <= op;
		i_dest_operand <= d;
		i_second_operand <= s;
		i_immediate <= k;
		i_io_rdata <= ~s;
		i_bit_sel <= b;
		i_io_addr <= d[4:0];
		i_next_is_two_word <= two;
		@(posedge i_mclk);
		// issue held into a stall must be ignored by the design
		i_issue <= hit;
		#1;
		n = 1;
		while (o_done !== 1'h1 && n < 8) begin
			@(posedge i_mclk);
			i_issue <= 1'h0;
			#1;
			n++;
		end
		exp_cyc = exp_q.pop_front();
		`CHK("cycles", exp_cyc, n)
		`CHK("pc", pc, o_program_counter)
		`CHK("status", st, o_status)
		`CHK("skip", hit, o_skip_taken)
		`CHK("io addr", d[4:0], o_io_addr)
	endtask : run
	initial begin
		logic [7:0] d, s;
		void'($urandom(30788));
		repeat (8) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		`CHK("reset status", 8'h00, o_status)
		for (int i = 0; i < 400; i++) begin
			d = 8'($urandom);
			s = $urandom_range(3) == 0 ? d : 8'($urandom);
			run(cse_pkg::cse_op_type'($urandom_range(7)), d, s,
				$urandom_range(1) ? d : 8'($urandom), 3'($urandom), 1'($urandom));
		end
		finish_test();
	end
	initial begin
		repeat (10000) @(posedge i_mclk);
		n_fail++;
		finish_test();
	end
endmodule : cse_exec_tb
bind cse_exec cse_exec_chk u_chk (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_issue(i_issue),
	.i_op(i_op),
	.i_dest_operand(i_dest_operand),
	.i_second_operand(i_second_operand),
	.i_immediate(i_immediate),
	.i_bit_sel(i_bit_sel),
	.i_next_is_two_word(i_next_is_two_word),
	.i_io_rdata(i_io_rdata),
	.o_status(o_status),
	.o_program_counter(o_program_counter),
	.o_busy(o_busy),
	.o_done(o_done),
	.o_skip_taken(o_skip_taken)
);
